/* design/dat_regs.vh */
// Purpose: Register map, fields, reset values and modes of the DMA address translator.
// Assumes: APB with 32-bit data, each register one aligned word.
// Notes: Definitions only.
`ifndef DAT_REGS_VH
`define DAT_REGS_VH
`define DAT_OFS_UTIL 12'h000
`define DAT_OFS_WSTART 12'h004
`define DAT_OFS_WEND 12'h008
`define DAT_OFS_PMIDX 12'h00c
`define DAT_OFS_PMDATA 12'h010
`define DAT_OFS_STATUS 12'h014
`define DAT_MODE_HI 19
`define DAT_MODE_LO 18
`define DAT_ADDR32_BIT 0
`define DAT_MODE_COMPAT 2'h0
`define DAT_MODE_P512 2'h1
`define DAT_MODE_P4K 2'h2
`define DAT_UTIL_RST 32'h0000_0000
`define DAT_WIN_RST 30'h0000_0000
`define DAT_VALID_BIT 31
`define DAT_ST_BUSY 0
`define DAT_ST_UPPER 1
`define DAT_ST_INVALID 2
`define DAT_ST_ECC 3
`define DAT_STAT_START 4'h1
`define DAT_STAT_UPPER 4'h2
`define DAT_STAT_INVALID 4'h4
`define DAT_STAT_ECC 4'h8
`endif

/* design/dat_ecc.v */
// Purpose: 12-bit check code over one 32-bit page map entry.
// Assumes: Purely combinational; used both to generate and to verify codes.
// Notes: Bits 0-5 are Hamming position parities, bits 6-11 interleaved parities.
`timescale 1ns/1ps
module dat_ecc (
	input wire [31:0] data,
	output reg [11:0] code
);
	integer i;
	integer j;
	always @* begin
		code = 12'h000;
		for (i = 0; i < 6; i = i + 1) begin
			for (j = 0; j < 32; j = j + 1) begin
				if ((((j + 1) >> i) & 1) == 1)
					code[i] = code[i] ^ data[j];
				if ((j % 6) == i)
					code[i + 6] = code[i + 6] ^ data[j];
			end
		end
	end
endmodule // dat_ecc

/* design/dat_top.v */
// Purpose: DMA address translation between a 30-bit expansion bus and a 40-bit system bus.
// Assumes: Expansion and system request ports are on pclk; registers over APB.
// Notes: One DMA at a time; page map is a single-port array with registered read.
`timescale 1ns/1ps
`include "dat_regs.vh"
module dat_top #(
	parameter PM_AW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire exp_req,
	input wire exp_write,
	input wire [29:0] exp_addr,
	input wire [31:0] exp_wdata,
	output reg exp_accept,
	output reg exp_noclaim,
	output reg exp_rdone,
	output reg exp_rabort,
	output reg [31:0] exp_rdata,
	output reg sys_req,
	output reg sys_write,
	output reg [39:0] sys_addr,
	output reg [31:0] sys_wdata,
	input wire sys_gnt,
	input wire sys_rvalid,
	input wire [31:0] sys_rdata
);
	localparam S_IDLE = 5'b00001;
	localparam S_LOOK = 5'b00010;
	localparam S_CHECK = 5'b00100;
	localparam S_ARB = 5'b01000;
	localparam S_RWAIT = 5'b10000;

	reg [31:0] util_q;
	reg [29:0] wstart_q;
	reg [29:0] wend_q;
	reg [PM_AW-1:0] pmidx_q;
	reg [3:0] stat_q;
	reg [4:0] st_q;
	reg [29:0] ca_q;
	reg wr_q;
	reg [31:0] wd_q;
	reg [1:0] mode_q;
	reg [43:0] pm_rd_q;
	reg [43:0] pm_mem [0:(1<<PM_AW)-1];
	// Address width is frozen with the mode so one transfer never mixes the two.
	reg a32_q;
	wire [11:0] wr_code;
	wire [11:0] rd_code;
	wire [1:0] mode = util_q[`DAT_MODE_HI:`DAT_MODE_LO];
	wire apb_acc = psel && penable && !pready;
	wire pm_hit = paddr == `DAT_OFS_PMDATA;
	// Map accesses wait while the walk reads the array so both never hit one port.
	wire apb_go = apb_acc && !(pm_hit && st_q == S_LOOK);
	wire in_win = (exp_addr >= wstart_q) && (exp_addr < wend_q);

	// Upper-bit check for the active mode.
	function upper_ok;
		input [1:0] m;
		input [29:0] a;
		begin
			if (m == `DAT_MODE_P512)
				upper_ok = a[29:25] == 5'h00;
			else if (m == `DAT_MODE_P4K)
				upper_ok = a[29:28] == 2'h0;
			else
				upper_ok = !a[29];
		end
	endfunction

	// Page map index for the active mode.
	function [15:0] pm_index;
		input [1:0] m;
		input [29:0] a;
		begin
			if (m == `DAT_MODE_P4K)
				pm_index = a[27:12];
			else
				pm_index = a[24:9];
		end
	endfunction

	// Output address from mode, entry and input address.
	function [39:0] xlate;
		input [1:0] m;
		input [31:0] e;
		input [29:0] a;
		input a32;
		reg [39:0] x;
		begin
			if (m == `DAT_MODE_P512)
				x = {1'b0, e[29:0], a[8:0]};
			else if (m == `DAT_MODE_P4K)
				x = {1'b0, e[26:0], a[11:0]};
			else
				x = {11'h000, a[28:0]};
			if (a32)
				x[39:32] = 8'h00;
			xlate = x;
		end
	endfunction

	// Only the low PM_AW index bits address the array; a narrow build folds the map.
	wire [15:0] walk_full = pm_index(mode_q, ca_q);
	wire [PM_AW-1:0] walk_idx = walk_full[PM_AW-1:0];
	// The cycle that shows a refusal must not take the still-held request again.
	wire take = exp_req && !exp_noclaim;
	wire ent_valid = pm_rd_q[`DAT_VALID_BIT];
	// Any mismatch counts as uncorrectable: the block has no correction path.
	wire ent_ecc_bad = rd_code != pm_rd_q[43:32];

	dat_ecc u_gen (
		.data(pwdata),
		.code(wr_code)
	);

	dat_ecc u_chk (
		.data(pm_rd_q[31:0]),
		.code(rd_code)
	);

	// APB slave, one wait state, two for a map access during lookup: pready rises on the second access cycle, or the third for that map access.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			util_q <= `DAT_UTIL_RST;
			wstart_q <= `DAT_WIN_RST;
			wend_q <= `DAT_WIN_RST;
			pmidx_q <= {PM_AW{1'b0}};
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_go;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (apb_go) begin
				if (paddr == `DAT_OFS_UTIL) begin
					if (pwrite)
						util_q <= pwdata;
					prdata <= util_q;
				end else if (paddr == `DAT_OFS_WSTART) begin
					if (pwrite)
						wstart_q <= pwdata[29:0];
					prdata <= {2'h0, wstart_q};
				end else if (paddr == `DAT_OFS_WEND) begin
					if (pwrite)
						wend_q <= pwdata[29:0];
					prdata <= {2'h0, wend_q};
				end else if (paddr == `DAT_OFS_PMIDX) begin
					if (pwrite)
						pmidx_q <= pwdata[PM_AW-1:0];
					prdata <= {{(32-PM_AW){1'b0}}, pmidx_q};
				end else if (pm_hit) begin
					prdata <= pm_mem[pmidx_q][31:0];
				end else if (paddr == `DAT_OFS_STATUS) begin
					prdata <= {28'h000_0000, stat_q};
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// Page map array: software writes and walk reads share one port.
	always @(posedge pclk) begin
		if (apb_go && pm_hit && pwrite)
			pm_mem[pmidx_q] <= {wr_code, pwdata};
		if (st_q == S_LOOK)
			pm_rd_q <= pm_mem[walk_idx];
	end

	// DMA flow between the expansion side and the system side.
	// Idle takes a request, lookup checks upper bits and reads the map, check
	// tests the entry, arbitration holds the system request until grant, and a
	// read then waits for its data. Only one transfer is in flight at a time.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= S_IDLE;
			ca_q <= 30'h0000_0000;
			wr_q <= 1'b0;
			wd_q <= 32'h0000_0000;
			mode_q <= `DAT_MODE_COMPAT;
			a32_q <= 1'b0;
			stat_q <= 4'h0;
			exp_accept <= 1'b0;
			exp_noclaim <= 1'b0;
			exp_rdone <= 1'b0;
			exp_rabort <= 1'b0;
			exp_rdata <= 32'h0000_0000;
			sys_req <= 1'b0;
			sys_write <= 1'b0;
			sys_addr <= 40'h00_0000_0000;
			sys_wdata <= 32'h0000_0000;
		end else begin
			exp_accept <= 1'b0;
			exp_noclaim <= 1'b0;
			exp_rdone <= 1'b0;
			exp_rabort <= 1'b0;
			case (st_q)
			S_IDLE: begin
				if (take && !in_win) begin
					exp_noclaim <= 1'b1;
				end else if (take) begin
					exp_accept <= 1'b1;
					ca_q <= exp_addr;
					wr_q <= exp_write;
					wd_q <= exp_wdata;
					// Mode is frozen per transfer so a mid-walk change is harmless.
					mode_q <= (mode == `DAT_MODE_P512 || mode == `DAT_MODE_P4K) ?
						mode : `DAT_MODE_COMPAT;
					a32_q <= util_q[`DAT_ADDR32_BIT];
					stat_q <= `DAT_STAT_START;
					st_q <= S_LOOK;
				end
			end
			S_LOOK: begin
				if (!upper_ok(mode_q, ca_q)) begin
					stat_q <= `DAT_STAT_UPPER;
					exp_rabort <= !wr_q;
					st_q <= S_IDLE;
				end else if (mode_q == `DAT_MODE_COMPAT) begin
					sys_addr <= xlate(mode_q, 32'h0000_0000, ca_q, a32_q);
					st_q <= S_ARB;
				end else begin
					st_q <= S_CHECK;
				end
			end
			S_CHECK: begin
				if (!ent_valid || ent_ecc_bad) begin
					stat_q <= ent_valid ? `DAT_STAT_ECC : `DAT_STAT_INVALID;
					exp_rabort <= !wr_q;
					st_q <= S_IDLE;
				end else begin
					sys_addr <= xlate(mode_q, pm_rd_q[31:0], ca_q, a32_q);
					st_q <= S_ARB;
				end
			end
			S_ARB: begin
				sys_req <= 1'b1;
				sys_write <= wr_q;
				sys_wdata <= wd_q;
				if (sys_req && sys_gnt) begin
					sys_req <= 1'b0;
					stat_q[`DAT_ST_BUSY] <= !wr_q;
					// Write outcome is never reported back to the node.
					st_q <= wr_q ? S_IDLE : S_RWAIT;
				end
			end
			S_RWAIT: begin
				if (sys_rvalid) begin
					exp_rdata <= sys_rdata;
					exp_rdone <= 1'b1;
					stat_q[`DAT_ST_BUSY] <= 1'b0;
					st_q <= S_IDLE;
				end
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule // dat_top

/* tb/dat_top_sva.sv */
// Purpose: Port-level checks of the DMA address translator.
// Assumes: Single pclk domain, presetn active low.
// Notes: Bound to dat_top below.
`timescale 1ns/1ps
module dat_top_sva (
	input wire pclk,
	input wire presetn,
	input wire exp_req,
	input wire exp_accept,
	input wire exp_noclaim,
	input wire exp_rdone,
	input wire exp_rabort,
	input wire sys_req,
	input wire sys_write,
	input wire [39:0] sys_addr,
	input wire sys_gnt,
	input wire sys_rvalid
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait; sys_req && !sys_gnt; endsequence
	sequence s_gnt; sys_req && sys_gnt; endsequence
	property p_hold; s_wait |=> sys_req && $stable(sys_addr) && $stable(sys_write); endproperty
	a_hold: assert property (p_hold) else $error("system request changed before grant");
	property p_drop; s_gnt |=> !sys_req; endproperty
	a_drop: assert property (p_drop) else $error("system request kept after grant");
	property p_b39; sys_req |-> !sys_addr[39]; endproperty
	a_b39: assert property (p_b39) else $error("system address bit 39 set");
	property p_ans; exp_accept || exp_noclaim |-> $past(exp_req); endproperty
	a_ans: assert property (p_ans) else $error("answer without request");
	property p_excl; exp_accept |-> !exp_noclaim && !sys_req; endproperty
	a_excl: assert property (p_excl) else $error("accept clashes with other answer");
	property p_rd; exp_rdone |-> $past(sys_rvalid) && !exp_rabort; endproperty
	a_rd: assert property (p_rd) else $error("read done without system data");
	property p_wr; s_gnt ##0 sys_write |=> !exp_rdone [*2]; endproperty
	a_wr: assert property (p_wr) else $error("status returned for a write");
	property p_nc; exp_noclaim |=> !sys_req [*3]; endproperty
	a_nc: assert property (p_nc) else $error("access issued for unclaimed request");
endmodule // dat_top_sva
bind dat_top dat_top_sva u_sva (.pclk, .presetn, .exp_req, .exp_accept, .exp_noclaim,
	.exp_rdone, .exp_rabort, .sys_req, .sys_write, .sys_addr, .sys_gnt, .sys_rvalid);

/* tb/dat_mem.sv */
// Purpose: System bus memory model with programmable grant latency.
// Assumes: One outstanding access.
// Notes: Read data is the address folded with a constant; lines toggle when idle.
`timescale 1ns/1ps
module dat_mem (
	input wire pclk,
	input wire presetn,
	input wire sys_req,
	input wire sys_write,
	input wire [39:0] sys_addr,
	input wire [31:0] sys_wdata,
	input wire [3:0] lat,
	output reg sys_gnt,
	output reg sys_rvalid,
	output reg [31:0] sys_rdata,
	output reg [39:0] last_a,
	output reg [31:0] last_d,
	output reg [7:0] n
);
	reg [3:0] c_q;
	reg pend_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{sys_gnt, sys_rvalid, sys_rdata, last_a, last_d, n, c_q, pend_q} <= 0;
		end else begin
			sys_gnt <= 1'b0;
			sys_rvalid <= 1'b0;
			sys_rdata <= ~sys_rdata;
			if (sys_req && !sys_gnt) begin
				c_q <= c_q + 4'h1;
				if (c_q >= lat) begin
					sys_gnt <= 1'b1;
					c_q <= 4'h0;
				end
			end
			if (sys_req && sys_gnt) begin
				last_a <= sys_addr;
				last_d <= sys_wdata;
				n <= n + 8'h1;
				pend_q <= !sys_write;
			end
			if (pend_q) begin
				sys_rvalid <= 1'b1;
				sys_rdata <= last_a[31:0] ^ 32'ha5a5;
				pend_q <= 1'b0;
			end
		end
	end
endmodule // dat_mem

/* tb/dat_top_bench.sv */
// Purpose: Self-checking bench of the DMA address translator.
// Assumes: Design built with a 4-bit page map index.
// Notes: Window end is exclusive, so an address equal to the window end is refused.
`timescale 1ns/1ps
`include "dat_regs.vh"
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin mismatches++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, x); end end
module dat_top_bench;
	reg pclk, presetn, psel, penable, pwrite, exp_req, exp_write, pe, s;
	reg [11:0] paddr;
	reg [31:0] pwdata, exp_wdata, e, d, rd, sd;
	reg [29:0] exp_addr, a;
	reg [3:0] lat;
	reg [1:0] m, f;
	reg [7:0] k;
	reg [39:0] x;
	wire [31:0] prdata, exp_rdata, sys_wdata, sys_rdata, last_d;
	wire [39:0] sys_addr, last_a;
	wire [7:0] n;
	wire pready, pslverr, exp_accept, exp_noclaim, exp_rdone, exp_rabort;
	wire sys_req, sys_write, sys_gnt, sys_rvalid;
	int mismatches = 0, total_checks = 0, cyc = 0, i;
	dat_top #(.PM_AW(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .exp_req, .exp_write, .exp_addr, .exp_wdata, .exp_accept,
		.exp_noclaim, .exp_rdone, .exp_rabort, .exp_rdata, .sys_req, .sys_write, .sys_addr,
		.sys_wdata, .sys_gnt, .sys_rvalid, .sys_rdata);
	dat_mem mem_u (.pclk, .presetn, .sys_req, .sys_write, .sys_addr, .sys_wdata, .lat,
		.sys_gnt, .sys_rvalid, .sys_rdata, .last_a, .last_d, .n);
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) if (++cyc > 20000) begin mismatches++; final_report; end
	function [31:0] rnd;
		sd ^= sd << 13; sd ^= sd >> 17; sd ^= sd << 5;
		rnd = sd;
	endfunction
	function [39:0] xa(input [1:0] mm, input ss, input [31:0] ee, input [29:0] aa);
		xa = mm == 1 ? {1'b0, ee[29:0], aa[8:0]} :
			mm == 2 ? {1'b0, ee[26:0], aa[11:0]} : {11'h0, aa[28:0]};
		if (ss) xa[39:32] = 8'h0;
	endfunction
	task apb(input w, input [11:0] ad, input [31:0] wd);
		@(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata; pe = pslverr; {psel, penable} <= 2'b00;
	endtask
	task ex(input w, input [29:0] ad, input [31:0] wd);
		@(posedge pclk) {exp_req, exp_write, exp_addr, exp_wdata} <= {1'b1, w, ad, wd};
		do @(posedge pclk); while (exp_accept !== 1'b1 && exp_noclaim !== 1'b1);
		f = {1'b0, exp_noclaim}; exp_req <= 1'b0;
		if (exp_accept && !w) begin
			do @(posedge pclk); while (exp_rdone !== 1'b1 && exp_rabort !== 1'b1);
			f[1] = exp_rabort;
		end
		do apb(0, `DAT_OFS_STATUS, 0); while (rd[`DAT_ST_BUSY] !== 1'b0);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, exp_req, exp_write, exp_addr, exp_wdata} = 0;
		presetn = 0; lat = 0; sd = 32'hd871;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `DAT_OFS_UTIL, 0); `CHK(rd, `DAT_UTIL_RST)
		apb(1, 12'h0fc, 0); `CHK(pe, 1'b1)
		for (i = 0; i < 6; i++) begin
			m = i % 3; s = i / 3; lat <= 4'(i * 2);
			apb(1, `DAT_OFS_UTIL, {12'h0, m, 17'h0, s});
			apb(1, `DAT_OFS_WSTART, 0);
			apb(1, `DAT_OFS_WEND, m == 1 ? 32'h200_0000 : m == 2 ? 32'h1000_0000 : 32'h3000_0000);
			a = 30'(rnd() & (m == 1 ? 32'h1ff_ffff : m == 2 ? 32'hfff_ffff : 32'h1fff_ffff));
			e = rnd() | 32'h8000_0000;
			apb(1, `DAT_OFS_PMIDX, m == 1 ? a[24:9] : a[27:12]);
			apb(1, `DAT_OFS_PMDATA, e);
			d = rnd(); k = n; x = xa(m, s, e, a);
			ex(1, a, d); `CHK(last_a, x)
			`CHK(last_d, d)
			ex(0, a, 0); `CHK(f, 2'b00)
			`CHK(exp_rdata, x[31:0] ^ 32'ha5a5)
			`CHK(n, k + 8'h2)
		end
		apb(1, `DAT_OFS_PMDATA, e & 32'h7fff_ffff);
		k = n; ex(0, a, 0); `CHK(f, 2'b10)
		ex(1, a, d); `CHK(n, k)
		ex(1, 30'h1000_0000, d); `CHK(f, 2'b01)
		apb(1, `DAT_OFS_WSTART, 32'h100);
		ex(0, 30'h0ff, 0); `CHK(f, 2'b01)
		apb(1, `DAT_OFS_UTIL, 32'h000c_0000); apb(1, `DAT_OFS_WEND, 32'h3000_0000);
		ex(0, a | 30'h2000_0000, 0); `CHK(f, 2'b10)
		ex(1, a | 30'h2000_0000, d); `CHK(n, k)
		final_report;
	end
endmodule // dat_top_bench
